//--- verif/eccc_host_model.sv
// serial host model that frames commands toward the block
`timescale 1ns/1ps

module eccc_host_model (
  input  wire logic clock,
  output logic      spi_clk,
  output logic      spi_cs_n,
  output logic      spi_io0_in,
  input  wire logic spi_io1_out,
  input  wire logic spi_io1_oe
);
  // idle bus: select high, serial clock parked low
  initial begin
    spi_clk    = 1'b0;
    spi_cs_n   = 1'b1;
    spi_io0_in = 1'b0;
  end

  // wait some system clock edges
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  // n bits out msb first, then nrd bits read back
  task automatic frame(input logic [55:0] tx, input int n,
                       input int nrd, output logic [7:0] rx,
                       output logic oe_ok);
    rx    = 8'h00;
    oe_ok = 1'b1;
    @(posedge clock);
    spi_cs_n <= 1'b0;
    tick(4);
    // opcode, address and dummy bits, mode 0
    for (int i = 0; i < n; i++) begin
      spi_io0_in <= tx[55-i];
      tick(4);
      spi_clk <= 1'b1;
      tick(4);
      spi_clk <= 1'b0;
    end
    // read phase: sample halfway through the high half, input line churns
    for (int j = 0; j < nrd; j++) begin
      spi_io0_in <= ~spi_io0_in;
      tick(4);
      spi_clk <= 1'b1;
      tick(2);
      rx    = {rx[6:0], spi_io1_out};
      oe_ok = oe_ok & spi_io1_oe;
      tick(2);
      spi_clk <= 1'b0;
    end
    tick(4);
    spi_cs_n   <= 1'b1;
    spi_io0_in <= ~spi_io0_in;
    tick(6);
  endtask
endmodule

//--- verif/eccc_properties.sv
// assertion checker for the error trap and checksum command block
`timescale 1ns/1ps

module eccc_properties #(
  parameter int CNT_W = 16
) (
  input wire logic                    clock,
  input wire logic                    sys_rst,
  input wire logic                    spi_cs_n,
  input wire logic                    spi_io1_oe,
  input wire eccc_pkg::eccc_err_evt_t err_evt,
  input wire logic                    dpd_active,
  input wire eccc_pkg::eccc_chk_cmd_t chk_cmd,
  input wire logic                    chk_done,
  input wire logic                    operation_in_progress,
  input wire logic                    checksum_suspended,
  input wire logic [31:0]             first_error_address_trap,
  input wire logic                    multibit_detect_flag,
  input wire logic [CNT_W-1:0]        uncorrectable_error_count
);
  import eccc_pkg::*;

  logic        cs_q;     // select one cycle ago
  logic [2:0]  cs_still; // cycles select has been steady
  logic [23:0] last_evt; // error address of the previous cycle

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // steady select means no clear command can be landing now
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cs_q     <= 1'b1;
      cs_still <= 3'd0;
    end else begin
      cs_q <= spi_cs_n;
      if (cs_q != spi_cs_n) begin
        cs_still <= 3'd0;
      end else if (cs_still != 3'd7) begin
        cs_still <= cs_still + 3'd1;
      end
    end
  end

  // keep each address one cycle for the trap comparison
  always_ff @(posedge clock) begin
    last_evt <= err_evt.addr;
  end

  // an error report away from any clear or power-down
  sequence s_quiet_evt;
    err_evt.valid && !dpd_active && cs_still >= 3'd6;
  endsequence

  // select has been high for four cycles
  sequence s_cs_high;
    spi_cs_n [*4];
  endsequence

  a_trap_first: assert property (
    err_evt.valid && !multibit_detect_flag && !dpd_active |=>
    first_error_address_trap == {8'h00, last_evt[23:3], 3'b000})
    else $error("trap missed first error address");
  a_trap_holds: assert property (
    s_quiet_evt ##0 multibit_detect_flag |=>
    $stable(first_error_address_trap))
    else $error("trap overwritten by later error");
  a_count_step: assert property (
    s_quiet_evt ##0 (uncorrectable_error_count != '1) |=>
    uncorrectable_error_count ==
    CNT_W'($past(uncorrectable_error_count) + 1'b1))
    else $error("error count did not step by one");
  a_count_sat: assert property (
    uncorrectable_error_count == '1 && !dpd_active &&
    cs_still >= 3'd6 |=> uncorrectable_error_count == '1)
    else $error("error count wrapped");
  a_flag_sets: assert property (
    err_evt.valid && !dpd_active |=> multibit_detect_flag)
    else $error("flag not set by error report");
  a_dpd_clears: assert property (
    dpd_active && !err_evt.valid |=> first_error_address_trap ==
    32'h00000000 && !multibit_detect_flag &&
    uncorrectable_error_count == '0)
    else $error("power-down left error state");
  a_start_runs: assert property (
    chk_cmd.start |-> operation_in_progress && !checksum_suspended)
    else $error("start without busy");
  a_suspend_idle: assert property (
    chk_cmd.suspend |-> $past(operation_in_progress) &&
    checksum_suspended && !operation_in_progress)
    else $error("suspend wrong");
  a_resume_runs: assert property (
    chk_cmd.resume |-> $past(checksum_suspended) &&
    operation_in_progress)
    else $error("resume wrong");
  a_oe_released: assert property (
    s_cs_high |=> !spi_io1_oe)
    else $error("output enabled while deselected");
endmodule

bind eccc_top eccc_properties #(.CNT_W(CNT_W)) i_props (
  .clock, .sys_rst, .spi_cs_n, .spi_io1_oe, .err_evt, .dpd_active,
  .chk_cmd, .chk_done, .operation_in_progress, .checksum_suspended,
  .first_error_address_trap, .multibit_detect_flag,
  .uncorrectable_error_count
);

//--- verif/testbench.sv
// self-checking bench for the error trap and checksum command block
`timescale 1ns/1ps

module testbench;
  import eccc_pkg::*;

  logic          clock, sys_rst, dpd_active, unit_multibit_in;
  logic          chk_done, spi_clk, spi_cs_n, spi_io0_in;
  logic          spi_io1_out, spi_io1_oe, operation_in_progress;
  logic          checksum_suspended, checksum_abort;
  logic          multibit_detect_flag, ok, m;
  logic [3:0]    memory_latency_code;
  logic [17:0]   unit_query_addr;
  logic [31:0]   first_error_address_trap;
  logic [15:0]   uncorrectable_error_count;
  logic [23:0]   first, a, s;
  logic [7:0]    rx;
  eccc_err_evt_t err_evt;
  eccc_chk_cmd_t chk_cmd;
  int            error_cnt, checked, starts, seed, lat, i;

  eccc_host_model host (.clock, .spi_clk, .spi_cs_n, .spi_io0_in,
                        .spi_io1_out, .spi_io1_oe);
  eccc_top i_dut (.clock, .sys_rst, .spi_clk, .spi_cs_n, .spi_io0_in,
    .spi_io1_out, .spi_io1_oe, .err_evt, .dpd_active,
    .memory_latency_code, .unit_query_addr, .unit_multibit_in,
    .chk_cmd, .chk_done, .operation_in_progress, .checksum_suspended,
    .checksum_abort, .first_error_address_trap, .multibit_detect_flag,
    .uncorrectable_error_count);

  // 25 MHz system clock
  always #20 clock = ~clock;

  // count start pulses toward the checksum engine
  always @(posedge clock) begin
    if (chk_cmd.start === 1'b1)
      starts <= starts + 1;
  end

  // expected trap: unit aligned address, top byte zero
  function automatic logic [31:0] trap_of(input logic [23:0] ad);
    return {8'h00, ad[23:3], 3'b000};
  endfunction

  // expected unit status byte
  function automatic logic [7:0] ustat(input logic mb);
    return {4'h0, mb, 3'b000};
  endfunction

  // compare and count
  task automatic check_eq(input string what, input logic [31:0] seen,
                          input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // print the verdict and stop
  task automatic summarize();
    if (error_cnt == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // one frame through the host model
  task automatic xfer(input logic [55:0] tx, input int n, input int r);
    host.frame(tx, n, r, rx, ok);
  endtask

  // read one register byte and compare it
  task automatic rdreg(input logic [23:0] ra, input logic [7:0] exp);
    xfer({8'h65, ra, 24'h000000}, 32 + lat, 8);
    check_eq("register byte", rx, exp);
  endtask

  // one-cycle error report from the read path
  task automatic evt(input logic [23:0] ad);
    err_evt <= {1'b1, ad};
    @(posedge clock);
    err_evt.valid <= 1'b0;
    @(posedge clock);
  endtask

  // watchdog against a hung handshake
  initial begin
    repeat (90000) @(posedge clock);
    error_cnt++;
    summarize();
  end

  initial begin
    seed = 32'h04D164E1;
    {clock, dpd_active, unit_multibit_in, chk_done} = 4'h0;
    {error_cnt, checked, starts, lat} = 128'h0;
    err_evt = '0;
    memory_latency_code = 4'h0;
    sys_rst = 1'b1;
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clock);
    check_eq("trap", first_error_address_trap, 32'h0);
    // first report is trapped, later ones only counted
    first = 24'($random(seed));
    evt(first);
    for (i = 0; i < 4; i++)
      evt(24'($random(seed)));
    check_eq("trap", first_error_address_trap, trap_of(first));
    check_eq("count", uncorrectable_error_count, 32'h5);
    check_eq("flag", multibit_detect_flag, 1'b1);
    for (i = 0; i < 4; i++)
      rdreg(24'h000014 + 24'(i), 8'(trap_of(first) >> (8 * i)));
    rdreg(24'h000010, 8'h10);
    // unit status reads, latency corners then random
    for (i = 0; i < 6; i++) begin
      lat = (i < 2) ? 15 * i : $random(seed) & 15;
      a = 24'($random(seed));
      m = 1'($random(seed));
      memory_latency_code <= 4'(lat);
      unit_multibit_in <= m;
      xfer({8'h19, a, 24'h000000}, 32 + lat, 8);
      check_eq("unit", unit_query_addr, a[20:3]);
      check_eq("status", rx, ustat(m));
      check_eq("oe", ok, 1'b1);
    end
    // clear with a stray bit is refused, exact one clears
    xfer({8'h1B, 48'h0}, 9, 0);
    check_eq("count", uncorrectable_error_count, 32'h5);
    xfer({8'h1B, 48'h0}, 8, 0);
    check_eq("trap", first_error_address_trap, 32'h0);
    check_eq("flag", multibit_detect_flag, 1'b0);
    check_eq("count", uncorrectable_error_count, 32'h0);
    // power-down wipes a captured error
    evt(first);
    dpd_active <= 1'b1;
    repeat (3) @(posedge clock);
    dpd_active <= 1'b0;
    @(posedge clock);
    rdreg(24'h000014, 8'h00);
    check_eq("trap", first_error_address_trap, 32'h0);
    // a report every cycle until the count saturates
    first = 24'($random(seed));
    err_evt <= {1'b1, first};
    repeat (65540) begin
      @(posedge clock);
      err_evt <= {1'b1, 24'($random(seed))};
    end
    @(posedge clock);
    err_evt.valid <= 1'b0;
    @(posedge clock);
    check_eq("count", uncorrectable_error_count, 32'hFFFF);
    rdreg(24'h000011, 8'hFF);
    rdreg(24'h000012, 8'hFF);
    check_eq("trap", first_error_address_trap, trap_of(first));
    // checksum start at the minimum range, short frame refused
    s = {4'h0, 20'($random(seed))};
    xfer({8'h5B, s, s + 24'h3}, 55, 0);
    check_eq("busy", operation_in_progress, 1'b0);
    xfer({8'h5B, s, s + 24'h3}, 56, 0);
    check_eq("starts", starts, 32'h1);
    check_eq("start addr", chk_cmd.start_addr, s);
    check_eq("end addr", chk_cmd.end_addr, s + 24'h3);
    rdreg(24'h000000, 8'h01);
    for (i = 0; i < 2; i++) begin
      xfer({8'h75, 48'h0}, 8, 0);
      check_eq("susp", checksum_suspended, 1'b1);
      check_eq("busy", operation_in_progress, 1'b0);
    end
    xfer({8'h7A, 48'h0}, 8, 0);
    check_eq("busy", operation_in_progress, 1'b1);
    chk_done <= 1'b1;
    @(posedge clock);
    chk_done <= 1'b0;
    @(posedge clock);
    check_eq("busy", operation_in_progress, 1'b0);
    xfer({8'h7A, 48'h0}, 8, 0);
    check_eq("busy", operation_in_progress, 1'b0);
    // range too short aborts without a start
    xfer({8'h5B, s, s + 24'h2}, 56, 0);
    check_eq("abort", checksum_abort, 1'b1);
    check_eq("starts", starts, 32'h1);
    summarize();
  end
endmodule

//--- verilog/eccc_cfg.svh
// constants for the error trap and checksum command block
`ifndef ECCC_CFG_SVH
`define ECCC_CFG_SVH

// opcodes
`define ECCC_OP_UNIT_STATUS   8'h19
`define ECCC_OP_ERROR_CLEAR   8'h1B
`define ECCC_OP_READ_ANY      8'h65
`define ECCC_OP_CHK_COMPUTE   8'h5B
`define ECCC_OP_CHK_SUSPEND   8'h75
`define ECCC_OP_CHK_RESUME    8'h7A

// frame lengths in serial bits, opcode included, and last bit indices within each phase
`define ECCC_BITS_OPCODE      7'd8
`define ECCC_BITS_CHK_FRAME   7'd56
`define ECCC_BITS_MAX         7'h7F
`define ECCC_LAST_ADDR_BIT    6'd23
`define ECCC_LAST_RANGE_BIT   6'd47
`define ECCC_LAST_OP_BIT      6'd7

// array and counter sizes
`define ECCC_ADDR_W           21
`define ECCC_CNT_W            16
`define ECCC_UNIT_LSB         3
`define ECCC_MIN_RANGE        24'h000003

// register addresses seen by the read-any-register command
`define ECCC_RA_STATUS_ONE    24'h000000
`define ECCC_RA_ERR_STATUS    24'h000010
`define ECCC_RA_COUNT_LO      24'h000011
`define ECCC_RA_COUNT_HI      24'h000012
`define ECCC_RA_TRAP_B0       24'h000014
`define ECCC_RA_TRAP_B1       24'h000015
`define ECCC_RA_TRAP_B2       24'h000016
`define ECCC_RA_TRAP_B3       24'h000017

// bit positions and reset values
`define ECCC_BIT_BUSY         0
`define ECCC_BIT_MULTIBIT     4
`define ECCC_BIT_UNIT_FLAG    3
`define ECCC_TRAP_RESET       32'h00000000
`define ECCC_COUNT_RESET      16'h0000

`endif

//--- verilog/eccc_pkg.sv
// types shared by the error trap and checksum command block
package eccc_pkg;

  // serial frame phases, gray along cmd, addr, dummy, data
  typedef enum logic [2:0] {
    ECCC_SP_CMD   = 3'b000,
    ECCC_SP_ADDR  = 3'b001,
    ECCC_SP_DUMMY = 3'b011,
    ECCC_SP_DATA  = 3'b010,
    ECCC_SP_SKIP  = 3'b110
  } eccc_spi_state_t;

  // checksum engine control, gray along idle, run, suspended
  typedef enum logic [1:0] {
    ECCC_CK_IDLE = 2'b00,
    ECCC_CK_RUN  = 2'b01,
    ECCC_CK_SUSP = 2'b11
  } eccc_chk_state_t;

  // uncorrectable error report from the array read path
  typedef struct packed {
    logic        valid;
    logic [23:0] addr;
  } eccc_err_evt_t;

  // command bundle to the checksum engine
  typedef struct packed {
    logic        start;
    logic        suspend;
    logic        resume;
    logic [23:0] start_addr;
    logic [23:0] end_addr;
  } eccc_chk_cmd_t;

endpackage

//--- verilog/eccc_satcnt.sv
// saturating event counter with clear, an event beats the clear
`timescale 1ns/1ps

module eccc_satcnt #(
  parameter int W = 16
) (
  input  wire logic         clock,
  input  wire logic         sys_rst,
  input  wire logic         clr,
  input  wire logic         inc,
  output logic      [W-1:0] count
);
  // clear restarts at one when an event lands in the same cycle
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      count <= '0;
    end else if (clr) begin
      count <= inc ? W'(1) : '0;
    end else if (inc && (count != {W{1'b1}})) begin
      count <= count + W'(1);
    end
  end
endmodule

//--- verilog/eccc_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps

module eccc_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;  // first stage, read only by q

  // two stages on every edge
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

//--- verilog/eccc_top.sv
// error trap, unit status, error clear and checksum command logic
`timescale 1ns/1ps
`include "eccc_cfg.svh"

// What this block does
// - 32-bit volatile trap holds uncorrectable error address
// - trap keeps only first address since clear
// - later errors only bump the error counter
// - trap read only by read-any-register command
// - deep power-down empties trap, reads zero after
// - unit status read: opcode, three address bytes
// - low three address bits ignored selecting unit
// - dummy cycles follow memory latency code
// - one status byte out, then host raises select
// - extra clocks give zero data; reissue per unit
// - status bit 3 flags multibit error, rest zero
// - clear opcode wipes flags, trap, counter
// - clear needs no write enable
// - checksum covers main array only
// - compute opcode starts checksum over host range
// - suspend opcode pauses a running checksum
// - resume opcode continues a suspended checksum
// - multibit flag in error status bit four
// - error counter saturates, never wraps
// - single-bit errors corrected silently, never reported
// - busy bit set while checksum runs
module eccc_top #(
  parameter int ADDR_W = `ECCC_ADDR_W,
  parameter int CNT_W  = `ECCC_CNT_W
) (
  input  wire logic                   clock,
  input  wire logic                   sys_rst,
  input  wire logic                   spi_clk,
  input  wire logic                   spi_cs_n,
  input  wire logic                   spi_io0_in,
  output logic                        spi_io1_out,
  output logic                        spi_io1_oe,
  input  wire eccc_pkg::eccc_err_evt_t err_evt,
  input  wire logic                   dpd_active,
  input  wire logic [3:0]             memory_latency_code,
  output logic [ADDR_W-4:0]           unit_query_addr,
  input  wire logic                   unit_multibit_in,
  output eccc_pkg::eccc_chk_cmd_t     chk_cmd,
  input  wire logic                   chk_done,
  output logic                        operation_in_progress,
  output logic                        checksum_suspended,
  output logic                        checksum_abort,
  output logic [31:0]                 first_error_address_trap,
  output logic                        multibit_detect_flag,
  output logic [CNT_W-1:0]            uncorrectable_error_count
);
  import eccc_pkg::*;

  // synchronised pins
  logic [2:0]      pins_s;          // clk, select high-true, data in
  logic            sclk_s;          // serial clock, synchronised
  logic            cs_n_s;          // chip select low, synchronised
  logic            mosi_s;          // serial data in, synchronised
  logic            sclk_q;          // previous serial clock
  logic            cs_n_q;          // previous chip select
  logic            sclk_rise;       // sampling edge inside a frame
  logic            sclk_fall;       // launch edge inside a frame
  logic            cs_rise;         // end of frame

  // frame decoder state
  eccc_spi_state_t sp_state;        // current frame phase
  logic [7:0]      opcode;          // shifted opcode
  logic [5:0]      bit_cnt;         // bits within the phase
  logic [6:0]      total;           // bits in frame, saturating
  logic [47:0]     addr_sh;         // address or range bits
  logic [3:0]      dum_cnt;         // dummy cycles seen
  logic [7:0]      out_sh;          // outgoing byte
  logic            data_started;    // first byte bit launched
  logic [7:0]      next_opcode;     // opcode including this bit
  logic [7:0]      resp_byte;       // byte to return
  logic [23:0]     reg_addr;        // address of the read

  // command strobes, valid in the cs_rise cycle; err_clear also while dpd_active
  logic            clr_cmd;         // error clear
  logic            err_clear;       // clear from command or power-down
  logic            start_cmd;       // checksum compute
  logic            susp_cmd;        // checksum suspend
  logic            resume_cmd;      // checksum resume

  // error tracking
  logic            trap_valid;      // trap already holds a capture
  eccc_chk_state_t ck_state;        // checksum engine control

  // pin synchroniser
  eccc_sync #(
    .W (3)
  ) u_sync (
    .clock   (clock),
    .sys_rst (sys_rst),
    .d       ({spi_clk, ~spi_cs_n, spi_io0_in}),
    .q       (pins_s)
  );

  assign sclk_s = pins_s[2];
  // select rides inverted so the reset value matches its idle level
  assign cs_n_s = ~pins_s[1];
  assign mosi_s = pins_s[0];

  // previous values for edge detection
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
    end else begin
      sclk_q <= sclk_s;
      cs_n_q <= cs_n_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_q & ~cs_n_s;
  assign sclk_fall = ~sclk_s & sclk_q & ~cs_n_s;
  assign cs_rise   = cs_n_s & ~cs_n_q;
  assign next_opcode = {opcode[6:0], mosi_s};

  // frame phases, sampled on serial clock rising edges
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sp_state <= ECCC_SP_CMD;
      opcode   <= 8'h00;
      bit_cnt  <= 6'h00;
      total    <= 7'h00;
      addr_sh  <= 48'h000000000000;
      dum_cnt  <= 4'h0;
    end else if (cs_n_s) begin
      // select high ends any frame; opcode kept for cs_rise decode
      sp_state <= ECCC_SP_CMD;
      bit_cnt  <= 6'h00;
      total    <= 7'h00;
      dum_cnt  <= 4'h0;
    end else if (sclk_rise) begin
      if (total != `ECCC_BITS_MAX) begin
        total <= total + 7'd1;
      end
      unique case (sp_state)
        ECCC_SP_CMD: begin
          opcode <= next_opcode;
          if (bit_cnt == `ECCC_LAST_OP_BIT) begin
            bit_cnt <= 6'h00;
            // only address-taking commands go on to an address phase
            if (next_opcode == `ECCC_OP_UNIT_STATUS ||
                next_opcode == `ECCC_OP_READ_ANY ||
                next_opcode == `ECCC_OP_CHK_COMPUTE) begin
              sp_state <= ECCC_SP_ADDR;
            end else begin
              sp_state <= ECCC_SP_SKIP;
            end
          end else begin
            bit_cnt <= bit_cnt + 6'd1;
          end
        end
        ECCC_SP_ADDR: begin
          addr_sh <= {addr_sh[46:0], mosi_s};
          bit_cnt <= bit_cnt + 6'd1;
          if (opcode == `ECCC_OP_CHK_COMPUTE) begin
            // start and end address, then nothing more to do
            if (bit_cnt == `ECCC_LAST_RANGE_BIT) begin
              sp_state <= ECCC_SP_SKIP;
            end
          end else if (bit_cnt == `ECCC_LAST_ADDR_BIT) begin
            // dummy count from the latency code
            if (memory_latency_code == 4'h0) begin
              sp_state <= ECCC_SP_DATA;
            end else begin
              sp_state <= ECCC_SP_DUMMY;
              dum_cnt  <= 4'h1;
            end
          end
        end
        ECCC_SP_DUMMY: begin
          if (dum_cnt == memory_latency_code) begin
            sp_state <= ECCC_SP_DATA;
          end else begin
            dum_cnt <= dum_cnt + 4'h1;
          end
        end
        ECCC_SP_DATA: begin
          // host bits ignored while the answer is shifted out
        end
        ECCC_SP_SKIP: begin
          // trailing bits only count toward the frame length
        end
      endcase
    end
  end

  // unit index drops the three low bits of the address
  assign unit_query_addr = addr_sh[ADDR_W-1:`ECCC_UNIT_LSB];
  assign reg_addr        = addr_sh[23:0];

  // answer byte for the active read command
  always_comb begin
    resp_byte = 8'h00;
    if (opcode == `ECCC_OP_UNIT_STATUS) begin
      // only the multibit flag bit, all others zero
      resp_byte[`ECCC_BIT_UNIT_FLAG] = unit_multibit_in;
    end else begin
      // trap is only reachable through this command
      unique case (reg_addr)
        `ECCC_RA_STATUS_ONE:
          resp_byte[`ECCC_BIT_BUSY] = operation_in_progress;
        `ECCC_RA_ERR_STATUS:
          resp_byte[`ECCC_BIT_MULTIBIT] = multibit_detect_flag;
        `ECCC_RA_COUNT_LO: resp_byte = uncorrectable_error_count[7:0];
        `ECCC_RA_COUNT_HI: resp_byte = uncorrectable_error_count[15:8];
        `ECCC_RA_TRAP_B0:
          resp_byte = first_error_address_trap[7:0];
        `ECCC_RA_TRAP_B1: resp_byte = first_error_address_trap[15:8];
        `ECCC_RA_TRAP_B2: resp_byte = first_error_address_trap[23:16];
        `ECCC_RA_TRAP_B3: resp_byte = first_error_address_trap[31:24];
        default:          resp_byte = 8'h00;
      endcase
    end
  end

  // output shifter, launched on serial clock falling edges
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      out_sh       <= 8'h00;
      spi_io1_out  <= 1'b0;
      spi_io1_oe   <= 1'b0;
      data_started <= 1'b0;
    end else if (cs_n_s) begin
      spi_io1_oe   <= 1'b0;
      spi_io1_out  <= 1'b0;
      data_started <= 1'b0;
    end else if (sclk_fall && sp_state == ECCC_SP_DATA) begin
      spi_io1_oe <= 1'b1;
      if (!data_started) begin
        // one byte, msb first
        spi_io1_out  <= resp_byte[7];
        out_sh       <= {resp_byte[6:0], 1'b0};
        data_started <= 1'b1;
      end else begin
        // past the byte the line shows zeros, which the host ignores
        spi_io1_out <= out_sh[7];
        out_sh      <= {out_sh[6:0], 1'b0};
      end
    end
  end

  // commands act on select rising after an exact frame length
  assign clr_cmd = cs_rise && opcode == `ECCC_OP_ERROR_CLEAR &&
                   total == `ECCC_BITS_OPCODE;
  assign start_cmd = cs_rise && opcode == `ECCC_OP_CHK_COMPUTE &&
                     total == `ECCC_BITS_CHK_FRAME;
  assign susp_cmd = cs_rise && opcode == `ECCC_OP_CHK_SUSPEND &&
                    total == `ECCC_BITS_OPCODE;
  assign resume_cmd = cs_rise && opcode == `ECCC_OP_CHK_RESUME &&
                      total == `ECCC_BITS_OPCODE;
  assign err_clear = clr_cmd | dpd_active;

  // multibit flag, a report in the clear cycle still sets it
  // single-bit corrections never arrive here, only uncorrectable ones
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      multibit_detect_flag <= 1'b0;
    end else begin
      multibit_detect_flag <= err_evt.valid |
                              (multibit_detect_flag & ~err_clear);
    end
  end

  // first error address trap
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      first_error_address_trap <= `ECCC_TRAP_RESET;
      trap_valid               <= 1'b0;
    end else if (err_evt.valid && (!trap_valid || err_clear)) begin
      // capture only the first unit address since the last clear
      first_error_address_trap <= {8'h00,
        err_evt.addr[23:`ECCC_UNIT_LSB], 3'b000};
      trap_valid               <= 1'b1;
    end else if (err_clear) begin
      // power-down or clear command empties the trap
      first_error_address_trap <= `ECCC_TRAP_RESET;
      trap_valid               <= 1'b0;
    end
  end

  // error counter, later errors only count
  eccc_satcnt #(
    .W (CNT_W)
  ) u_count (
    .clock   (clock),
    .sys_rst (sys_rst),
    .clr     (err_clear),
    .inc     (err_evt.valid),
    .count   (uncorrectable_error_count)
  );

  // checksum engine control
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ck_state       <= ECCC_CK_IDLE;
      checksum_abort <= 1'b0;
    end else begin
      unique case (ck_state)
        ECCC_CK_IDLE: begin
          if (start_cmd) begin
            // end must be at least three above start
            if (addr_sh[23:0] < addr_sh[47:24] + `ECCC_MIN_RANGE) begin
              checksum_abort <= 1'b1;
            end else begin
              ck_state       <= ECCC_CK_RUN;
              checksum_abort <= 1'b0;
            end
          end
        end
        ECCC_CK_RUN: begin
          // completion beats a suspend that arrives too late
          if (chk_done) begin
            ck_state <= ECCC_CK_IDLE;
          end else if (susp_cmd) begin
            ck_state <= ECCC_CK_SUSP;
          end
        end
        ECCC_CK_SUSP: begin
          if (resume_cmd) begin
            ck_state <= ECCC_CK_RUN;
          end
        end
        default: begin
          ck_state <= ECCC_CK_IDLE;
        end
      endcase
    end
  end

  // command strobes and range to the engine, main array only
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      chk_cmd <= '0;
    end else begin
      chk_cmd.start   <= start_cmd && ck_state == ECCC_CK_IDLE &&
                         !(addr_sh[23:0] < addr_sh[47:24] +
                           `ECCC_MIN_RANGE);
      chk_cmd.suspend <= susp_cmd && ck_state == ECCC_CK_RUN &&
                         !chk_done;
      chk_cmd.resume  <= resume_cmd && ck_state == ECCC_CK_SUSP;
      if (start_cmd && ck_state == ECCC_CK_IDLE) begin
        chk_cmd.start_addr <= {{(24-ADDR_W){1'b0}},
                               addr_sh[24+ADDR_W-1:24]};
        chk_cmd.end_addr   <= {{(24-ADDR_W){1'b0}},
                               addr_sh[ADDR_W-1:0]};
      end
    end
  end

  // busy while running, not while suspended
  assign operation_in_progress = (ck_state == ECCC_CK_RUN);
  assign checksum_suspended    = (ck_state == ECCC_CK_SUSP);
endmodule
